// ### src/isdc_cfg.svh
// Register offsets, field positions, reset values and widths of the controller
`ifndef ISDC_CFG_SVH
`define ISDC_CFG_SVH

`define ISDC_DATA_W 32
`define ISDC_ADDR_W 8
`define ISDC_HIER_CNT 4
`define ISDC_FIXED_SRC 5

// Hierarchy select: addr[7] low, addr[6:5] = 0 main, 1 port, 2 slow serdes, 3 fast serdes
`define ISDC_HIER_BIT 7
`define ISDC_HIER_MSB 6
`define ISDC_HIER_LSB 5

// Word index inside one hierarchy block, taken from addr[4:2]
`define ISDC_W_LEVEL 3'h0
`define ISDC_W_LATCH 3'h1
`define ISDC_W_SEL_LO 3'h2
`define ISDC_W_SEL_HI 3'h3
`define ISDC_W_ENA 3'h4
`define ISDC_W_PEND 3'h5
`define ISDC_W_SKIP 3'h6
`define ISDC_W_POL 3'h7

// Destination and external pin registers
`define ISDC_OFS_DST_MASK0 8'h80
`define ISDC_OFS_DST_MASK1 8'h84
`define ISDC_OFS_DST_VIEW0 8'h88
`define ISDC_OFS_DST_VIEW1 8'h8c
`define ISDC_OFS_EXT_IN_POL 8'h90
`define ISDC_OFS_EXT_OUT_POL 8'h94
`define ISDC_OFS_EXT_DRV 8'h98

// Aggregate and external source positions in the main source vector
`define ISDC_SRC_PORT 0
`define ISDC_SRC_SLOW 1
`define ISDC_SRC_FAST 2
`define ISDC_SRC_EXT0 3
`define ISDC_SRC_EXT1 4

`define ISDC_RST_WORD 32'h0000_0000
`define ISDC_RST_SEL 64'h0000_0000_0000_0000
`define ISDC_RST_PIN 2'h0
`define ISDC_RST_OE_B 2'h3

`endif

// ### src/isdc_pkg.sv
// Types shared by the interrupt source and destination controller
package isdc_pkg;

   typedef enum logic [1:0] {
      ISDC_LEVEL = 2'h0,
      ISDC_ANY_EDGE = 2'h1,
      ISDC_FALL = 2'h2,
      ISDC_RISE = 2'h3
   } isdc_detect_t;

   typedef logic [31:0] isdc_word_t;

endpackage

// ### src/isdc_top.sv
// Interrupt controller: source hierarchies, destinations and external pins
`timescale 1ns/1ps

module isdc_stage
   import isdc_pkg::*;
#(
   parameter int W = 32
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   // Source and configuration
   input wire logic [W-1:0] raw_in,
   input wire logic [2*W-1:0] detect_in,
   input wire logic [W-1:0] skip_in,
   input wire logic [W-1:0] enable_in,
   input wire logic [W-1:0] clear_in,
   // State
   output logic [W-1:0] latched_out,
   output logic [W-1:0] pending_out
);

   logic [W-1:0] prev;
   logic [W-1:0] latched;
   logic [W-1:0] hit;
   genvar i;
   for (i = 0; i < W; i++) begin : g_bit
      isdc_detect_t mode;
      logic hit_b;
      assign mode = isdc_detect_t'(detect_in[2*i +: 2]);
      always_comb begin
         case (mode)
            ISDC_LEVEL: hit_b = raw_in[i];
            ISDC_ANY_EDGE: hit_b = raw_in[i] ^ prev[i];
            ISDC_FALL: hit_b = prev[i] & ~raw_in[i];
            ISDC_RISE: hit_b = raw_in[i] & ~prev[i];
            default: hit_b = 1'b0;
         endcase
      end
      assign hit[i] = hit_b;
      level_set_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
         (mode == ISDC_LEVEL && raw_in[i]) |=> latched[i])
         else $error("level source did not latch");
      rise_only_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
         (mode == ISDC_RISE && !latched[i] && !(raw_in[i] && !prev[i])) |=> !latched[i])
         else $error("rising mode latched without rising edge");
      fall_set_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
         (mode == ISDC_FALL && $fell(raw_in[i])) |=> latched[i])
         else $error("falling edge not latched");
      edge_set_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
         (mode == ISDC_ANY_EDGE && raw_in[i] != prev[i]) |=> latched[i])
         else $error("edge not latched");
      clear_hit_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
         (clear_in[i] && hit_b) |=> latched[i])
         else $error("clear lost a simultaneous event");
      clear_done_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
         (clear_in[i] && !hit_b) |=> !latched[i])
         else $error("write one did not clear flag");
   end
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prev <= '0;
      end else begin
         prev <= raw_in;
      end
   end
   // Set wins over a clear in the same cycle
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         latched <= '0;
      end else begin
         latched <= hit | (latched & ~clear_in);
      end
   end
   assign latched_out = latched;
   assign pending_out = (skip_in & raw_in | ~skip_in & latched) & enable_in;
endmodule // isdc_stage

`include "isdc_cfg.svh"

module isdc_top
   import isdc_pkg::*;
#(
   parameter int NUM_SRC = 32,
   parameter int NUM_PORT = 32,
   parameter int NUM_SLOW = 8,
   parameter int NUM_FAST = 8
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   // Register port
   input wire logic [`ISDC_ADDR_W-1:0] reg_addr_in,
   input wire logic [`ISDC_DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [`ISDC_DATA_W-1:0] reg_rdata_out,
   // Interrupt sources, active high
   input wire logic [NUM_SRC-`ISDC_FIXED_SRC-1:0] peripheral_irq_in,
   input wire logic [NUM_PORT-1:0] port_module_irq_in,
   input wire logic [NUM_SLOW-1:0] slow_serdes_irq_in,
   input wire logic [NUM_FAST-1:0] fast_serdes_irq_in,
   // External request pins
   input wire logic external_request_input_zero_in,
   input wire logic external_request_input_one_in,
   output logic external_request_output_zero_out,
   output logic external_request_output_zero_oe_b_out,
   output logic external_request_output_one_out,
   output logic external_request_output_one_oe_b_out
);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   if (NUM_SRC < `ISDC_FIXED_SRC + 1 || NUM_SRC > 32 || NUM_PORT < 1 || NUM_PORT > 32 ||
       NUM_SLOW < 1 || NUM_SLOW > 32 || NUM_FAST < 1 || NUM_FAST > 32) begin : g_bad
      $error("isdc_top: source counts must lie in range");
   end

   localparam int HN = `ISDC_HIER_CNT;

   function automatic isdc_word_t width_mask(input int n);
      return isdc_word_t'((64'h1 << n) - 64'h1);
   endfunction

   localparam isdc_word_t MASK_MAIN = width_mask(NUM_SRC);
   localparam isdc_word_t MASK_PORT = width_mask(NUM_PORT);
   localparam isdc_word_t MASK_SLOW = width_mask(NUM_SLOW);
   localparam isdc_word_t MASK_FAST = width_mask(NUM_FAST);

   isdc_word_t hmask [HN];
   assign hmask = '{MASK_MAIN, MASK_PORT, MASK_SLOW, MASK_FAST};

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic in_hier;
   logic [1:0] hsel;
   logic [2:0] word;
   assign in_hier = !reg_addr_in[`ISDC_HIER_BIT] && reg_addr_in[1:0] == 2'h0;
   assign hsel = reg_addr_in[`ISDC_HIER_MSB:`ISDC_HIER_LSB];
   assign word = reg_addr_in[4:2];

   // ----------------------------------------------------------------
   // Source hierarchies
   // ----------------------------------------------------------------
   isdc_word_t hraw [HN];
   isdc_word_t hlatch [HN];
   isdc_word_t hpend [HN];
   isdc_word_t hena [HN];
   isdc_word_t hskip [HN];
   isdc_word_t hpol [HN];
   logic [63:0] hsel_cfg [HN];
   isdc_word_t hrd [HN];
   logic [1:0] ext_src;
   logic [1:0] ext_in_pol;

   assign ext_src = {external_request_input_one_in, external_request_input_zero_in} ^
                    ext_in_pol;

   // Polarity correction before entry, aggregation after the last stage
   assign hraw[1] = 32'(port_module_irq_in) ^ hpol[1];
   assign hraw[2] = 32'(slow_serdes_irq_in) ^ hpol[2];
   assign hraw[3] = 32'(fast_serdes_irq_in) ^ hpol[3];
   assign hraw[0] = 32'({peripheral_irq_in, ext_src, |hpend[3], |hpend[2],
                         |hpend[1]});

   genvar h;
   for (h = 0; h < HN; h++) begin : g_hier
      logic hit_sel;
      isdc_word_t wmask;
      isdc_word_t clr;
      assign hit_sel = in_hier && hsel == 2'(h);
      assign wmask = reg_wdata_in & hmask[h];
      assign clr = (reg_wr_in && hit_sel && word == `ISDC_W_LATCH) ? wmask : '0;
      // Select bits of absent sources stay zero
      logic [63:0] smask;
      for (genvar k = 0; k < 32; k++) begin : g_pair
         assign smask[2*k +: 2] = {2{hmask[h][k]}};
      end
      always_ff @(posedge clock_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            hsel_cfg[h] <= `ISDC_RST_SEL;
         end else if (reg_wr_in && hit_sel && word == `ISDC_W_SEL_LO) begin
            hsel_cfg[h][31:0] <= reg_wdata_in & smask[31:0];
         end else if (reg_wr_in && hit_sel && word == `ISDC_W_SEL_HI) begin
            hsel_cfg[h][63:32] <= reg_wdata_in & smask[63:32];
         end
      end
      always_ff @(posedge clock_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            hena[h] <= `ISDC_RST_WORD;
         end else if (reg_wr_in && hit_sel && word == `ISDC_W_ENA) begin
            hena[h] <= wmask;
         end
      end

      always_ff @(posedge clock_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            hskip[h] <= `ISDC_RST_WORD;
         end else if (reg_wr_in && hit_sel && word == `ISDC_W_SKIP) begin
            hskip[h] <= wmask;
         end
      end

      // Main hierarchy has no polarity stage
      always_ff @(posedge clock_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            hpol[h] <= `ISDC_RST_WORD;
         end else if (reg_wr_in && hit_sel && word == `ISDC_W_POL && h != 0) begin
            hpol[h] <= wmask;
         end
      end

      isdc_stage #(
         .W(32)
      ) u_stage (
         .clock_in(clock_in),
         .rst_b_in(rst_b_in),
         .raw_in(hraw[h] & hmask[h]),
         .detect_in(hsel_cfg[h]),
         .skip_in(hskip[h]),
         .enable_in(hena[h]),
         .clear_in(clr),
         .latched_out(hlatch[h]),
         .pending_out(hpend[h])
      );

      always_comb begin
         case (word)
            `ISDC_W_LEVEL: hrd[h] = hraw[h] & hmask[h];
            `ISDC_W_LATCH: hrd[h] = hlatch[h];
            `ISDC_W_SEL_LO: hrd[h] = hsel_cfg[h][31:0];
            `ISDC_W_SEL_HI: hrd[h] = hsel_cfg[h][63:32];
            `ISDC_W_ENA: hrd[h] = hena[h];
            `ISDC_W_PEND: hrd[h] = hpend[h];
            `ISDC_W_SKIP: hrd[h] = hskip[h];
            `ISDC_W_POL: hrd[h] = hpol[h];
            default: hrd[h] = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Destinations and external pin configuration
   // ----------------------------------------------------------------
   isdc_word_t dst_mask [2];
   isdc_word_t dst_view [2];
   logic [1:0] dst_level;
   logic [1:0] ext_out_pol;
   logic [1:0] ext_drv;

   for (h = 0; h < 2; h++) begin : g_dst
      logic [`ISDC_ADDR_W-1:0] ofs;
      assign ofs = (h == 0) ? `ISDC_OFS_DST_MASK0 : `ISDC_OFS_DST_MASK1;
      always_ff @(posedge clock_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            dst_mask[h] <= `ISDC_RST_WORD;
         end else if (reg_wr_in && reg_addr_in == ofs) begin
            dst_mask[h] <= reg_wdata_in & MASK_MAIN;
         end
      end
      assign dst_view[h] = hpend[0] & dst_mask[h];
      assign dst_level[h] = |dst_view[h];
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ext_in_pol <= `ISDC_RST_PIN;
         ext_out_pol <= `ISDC_RST_PIN;
         ext_drv <= `ISDC_RST_PIN;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `ISDC_OFS_EXT_IN_POL) begin
            ext_in_pol <= reg_wdata_in[1:0];
         end
         if (reg_addr_in == `ISDC_OFS_EXT_OUT_POL) begin
            ext_out_pol <= reg_wdata_in[1:0];
         end
         if (reg_addr_in == `ISDC_OFS_EXT_DRV) begin
            ext_drv <= reg_wdata_in[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // External output pins
   // ----------------------------------------------------------------
   logic [1:0] pin_val;
   logic [1:0] pin_oe_b;

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pin_val <= `ISDC_RST_PIN;
         pin_oe_b <= `ISDC_RST_OE_B;
      end else begin
         pin_val <= dst_level ^ ext_out_pol ^ ext_drv;
         pin_oe_b <= ext_drv & ~dst_level;
      end
   end

   assign external_request_output_zero_out = pin_val[0];
   assign external_request_output_one_out = pin_val[1];
   assign external_request_output_zero_oe_b_out = pin_oe_b[0];
   assign external_request_output_one_oe_b_out = pin_oe_b[1];

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   isdc_word_t next_rdata;
   isdc_word_t rdata;

   always_comb begin
      next_rdata = '0;
      if (reg_rd_in) begin
         if (in_hier) begin
            next_rdata = hrd[hsel];
         end else begin
            case (reg_addr_in)
               `ISDC_OFS_DST_MASK0: next_rdata = dst_mask[0];
               `ISDC_OFS_DST_MASK1: next_rdata = dst_mask[1];
               `ISDC_OFS_DST_VIEW0: next_rdata = dst_view[0];
               `ISDC_OFS_DST_VIEW1: next_rdata = dst_view[1];
               `ISDC_OFS_EXT_IN_POL: next_rdata = 32'(ext_in_pol);
               `ISDC_OFS_EXT_OUT_POL: next_rdata = 32'(ext_out_pol);
               `ISDC_OFS_EXT_DRV: next_rdata = 32'(ext_drv);
               default: next_rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata <= `ISDC_RST_WORD;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign reg_rdata_out = rdata;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   raw_read_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (reg_rd_in && reg_addr_in == 8'h00) |=> reg_rdata_out == $past(hraw[0] & MASK_MAIN))
      else $error("raw view read mismatch");
   port_agg_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      hraw[0][`ISDC_SRC_PORT] == |(hpend[1]))
      else $error("port aggregate mismatch");
   main_pend_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (hlatch[0][5] && hena[0][5] && !hskip[0][5]) |-> dst_view[0][5] == dst_mask[0][5])
      else $error("latched enabled source not forwarded");
   skip_raw_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (hskip[0][5] && hena[0][5]) |-> hpend[0][5] == hraw[0][5])
      else $error("skip does not follow raw level");
   drive_full_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (!ext_drv[0]) |=> !external_request_output_zero_oe_b_out &&
         external_request_output_zero_out == $past(dst_level[0] ^ ext_out_pol[0]))
      else $error("output zero not driven continuously");
   open_coll_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (ext_drv[1] && !ext_out_pol[1]) |=>
         (external_request_output_one_oe_b_out == !$past(dst_level[1])) &&
         ($past(dst_level[1]) -> !external_request_output_one_out))
      else $error("open collector emulation wrong");
   dst_view_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (reg_rd_in && reg_addr_in == `ISDC_OFS_DST_VIEW1) |=>
         reg_rdata_out == $past(hpend[0] & dst_mask[1]))
      else $error("destination view read mismatch");
   ext_pol_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      hraw[0][`ISDC_SRC_EXT0] == (external_request_input_zero_in ^ ext_in_pol[0]))
      else $error("external input polarity wrong");

endmodule // isdc_top

// ### verif/isdc_far_side.sv
// Behavioural model of the interrupt sources and the shared request wires
`timescale 1ns/1ps

module isdc_far_side (
   // Clock
   input wire logic clock_in,
   // Source lines, active high
   output logic [26:0] peripheral_irq_out,
   output logic [31:0] port_irq_out,
   output logic [7:0] slow_irq_out,
   output logic [7:0] fast_irq_out,
   output logic ext_zero_out,
   output logic ext_one_out,
   // Request pins and the wires behind them
   input wire logic zero_value_in,
   input wire logic zero_oe_b_in,
   input wire logic one_value_in,
   input wire logic one_oe_b_in,
   output logic zero_wire_out,
   output logic one_wire_out
);
   // ----------------------------------------
   // Wires with pull-up when released
   // ----------------------------------------
   assign zero_wire_out = zero_oe_b_in ? 1'b1 : zero_value_in;
   assign one_wire_out = one_oe_b_in ? 1'b1 : one_value_in;

   initial begin
      peripheral_irq_out = '0;
      port_irq_out = '0;
      slow_irq_out = '0;
      fast_irq_out = '0;
      ext_zero_out = 1'b0;
      ext_one_out = 1'b0;
   end

   // ----------------------------------------
   // Sources hold their level until changed
   // ----------------------------------------
   task automatic set_line(input int grp, input int idx, input logic v);
      case (grp)
         0: peripheral_irq_out[idx] <= v;
         1: port_irq_out[idx] <= v;
         2: slow_irq_out[idx] <= v;
         3: fast_irq_out[idx] <= v;
         4: ext_zero_out <= v;
         default: ext_one_out <= v;
      endcase
      @(posedge clock_in);
      @(posedge clock_in);
   endtask
endmodule // isdc_far_side

// ### verif/tb.sv
// Self-checking testbench of the interrupt controller
`timescale 1ns/1ps

module tb;
   import isdc_pkg::*;
   logic clock_in;
   logic rst_b_in;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic [26:0] periph;
   logic [31:0] port;
   logic [7:0] slow;
   logic [7:0] fast;
   logic ext0, ext1, v0, oe0, v1, oe1, w0, w1;
   logic [31:0] d;
   logic [7:0] base;
   logic [31:0] expq[$];
   logic rd_prev = 1'b0;
   int errors = 0;
   int comparisons = 0;
   int seed = 35644;
   localparam logic [31:0] B = 32'h0000_0020;

   isdc_top #(.NUM_SRC(32), .NUM_PORT(32), .NUM_SLOW(8), .NUM_FAST(8)) uut (
      .clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_rdata_out(reg_rdata), .peripheral_irq_in(periph), .port_module_irq_in(port),
      .slow_serdes_irq_in(slow), .fast_serdes_irq_in(fast),
      .external_request_input_zero_in(ext0), .external_request_input_one_in(ext1),
      .external_request_output_zero_out(v0), .external_request_output_zero_oe_b_out(oe0),
      .external_request_output_one_out(v1), .external_request_output_one_oe_b_out(oe1));

   isdc_far_side far (
      .clock_in(clock_in), .peripheral_irq_out(periph), .port_irq_out(port),
      .slow_irq_out(slow), .fast_irq_out(fast), .ext_zero_out(ext0), .ext_one_out(ext1),
      .zero_value_in(v0), .zero_oe_b_in(oe0), .one_value_in(v1), .one_oe_b_in(oe1),
      .zero_wire_out(w0), .one_wire_out(w1));

   // ----------------------------------------
   // Clock, checks and bus tasks
   // ----------------------------------------
   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Read data stand only in the cycle after the strobe
   always @(negedge clock_in) begin
      if (rd_prev && expq.size() > 0) begin
         chk(reg_rdata, expq.pop_front());
      end
      rd_prev = reg_rd;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      reg_addr <= a;
      reg_wdata <= dat;
      reg_wr <= 1'b1;
      @(posedge clock_in);
      reg_wr <= 1'b0;
      @(posedge clock_in);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock_in);
      reg_rd <= 1'b0;
      @(posedge clock_in);
   endtask

   // Pin order: zero value, zero output disable (high when released), one wire, one output disable (high when released)
   task automatic pin_chk(input logic [3:0] e);
      @(negedge clock_in);
      chk({28'h0, v0, oe0, w1, oe1}, {28'h0, e});
      @(posedge clock_in);
   endtask

   initial begin
      #(40 * 20000);
      errors++;
      final_report;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_b_in = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (16) @(posedge clock_in);
      rst_b_in <= 1'b1;
      @(posedge clock_in);
      rd(8'h10, 32'h0);
      rd(8'h98, 32'h0);
      rd(8'h80, 32'h0);
      rd(8'h3c, 32'h0);
      rd(8'ha0, 32'h0);
      pin_chk(4'b0000);
      for (int m = 0; m < 4; m++) begin
         wr(8'h08, 32'(m) << 10);
         rd(8'h08, 32'(m) << 10);
         wr(8'h04, 32'hffff_ffff);
         far.set_line(0, 0, 1'b1);
         rd(8'h04, (m != 2) ? B : 32'h0);
         wr(8'h04, B);
         rd(8'h04, (m == 0) ? B : 32'h0);
         far.set_line(0, 0, 1'b0);
         rd(8'h04, (m <= 2) ? B : 32'h0);
         wr(8'h04, B);
         rd(8'h04, 32'h0);
      end
      wr(8'h10, B);
      rd(8'h14, 32'h0);
      far.set_line(0, 0, 1'b1);
      rd(8'h00, B);
      rd(8'h14, B);
      wr(8'h04, B);
      rd(8'h14, 32'h0);
      wr(8'h18, B);
      rd(8'h14, B);
      wr(8'h10, 32'h0);
      rd(8'h14, 32'h0);
      wr(8'h10, B);
      rd(8'h88, 32'h0);
      wr(8'h80, B);
      rd(8'h88, B);
      rd(8'h8c, 32'h0);
      pin_chk(4'b1000);
      wr(8'h94, 32'h1);
      pin_chk(4'b0000);
      wr(8'h98, 32'h2);
      pin_chk(4'b0011);
      wr(8'h84, B);
      rd(8'h8c, B);
      pin_chk(4'b0000);
      far.set_line(0, 0, 1'b0);
      pin_chk(4'b1011);
      wr(8'h18, 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h04, 32'hffff_ffff);
      for (int h = 1; h < 4; h++) begin
         base = 8'(h * 32);
         far.set_line(h, 1, 1'b1);
         wr(base + 8'h10, 32'h2);
         rd(base + 8'h14, 32'h2);
         rd(8'h00, 32'h1 << (h - 1));
         wr(base + 8'h1c, 32'h1);
         rd(base, 32'h3);
         wr(base + 8'h1c, 32'h0);
         wr(base + 8'h10, 32'h0);
         rd(8'h00, 32'h0);
         far.set_line(h, 1, 1'b0);
         wr(base + 8'h04, 32'hffff_ffff);
         rd(base + 8'h04, 32'h0);
      end
      far.set_line(4, 0, 1'b1);
      rd(8'h00, 32'h08);
      far.set_line(5, 0, 1'b1);
      rd(8'h00, 32'h18);
      wr(8'h90, 32'h2);
      rd(8'h00, 32'h08);
      far.set_line(4, 0, 1'b0);
      far.set_line(5, 0, 1'b0);
      rd(8'h00, 32'h10);
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         wr(8'h50, d);
         rd(8'h50, {24'h0, d[7:0]});
         wr(8'h48, d);
         rd(8'h48, {16'h0, d[15:0]});
         wr(8'h00, d);
         rd(8'h00, 32'h10);
      end
      final_report;
   end
endmodule // tb
